// ### logic/dma_channel_transfer_engine.sv
// eight channel dma transfer engine between peripheral bus and dual port memory
//
// Behaviour
// - arbitrate requests; winner transfers next cycle
// - read peripheral address, write memory
// - register indirect uses primary or secondary start
// - peripheral indirect takes memory write address from peripheral
// - read and write phases are one transfer
// - request stays latched until transfer completes
// - count hits limit: block done, interrupt
// - keep arbitrating during a transfer
// - codes for ext int and capture units
// - codes for compare units and their registers
// - codes for serial ports, shared buffer
// - codes for first uart rx and tx
// - codes for second uart rx and tx
// - codes for can receive and transmit
// - code for codec, rx and tx buffers
// - codes for converter conversion done
// - shared source requests both channels at once
// - unmapped address: drop writes, read zero
// - forced request arbitrates like any other
//
// The register addresses and strobed register access were decided locally.
`timescale 1ns/10ps
`default_nettype none
module dma_channel_transfer_engine
  import dma_pkg::*;
(
  input  wire logic                           core_clk_i,
  input  wire logic                           rst_i,
  input  wire dma_pkg::reg_req_type           reg_bus_i,
  output var  logic [dma_pkg::DW-1:0]         reg_rdata_o,
  input  wire logic [dma_pkg::NSRC-1:0]       periph_req_i,
  input  wire logic [dma_pkg::DW-1:0]         periph_rdata_i,
  input  wire logic [dma_pkg::DW-1:0]         periph_ind_addr_i,
  input  wire logic [dma_pkg::DW-1:0]         mem_rdata_i,
  output var  logic                           periph_rd_o,
  output var  logic [dma_pkg::DW-1:0]         periph_raddr_o,
  output var  logic [dma_pkg::SRC_W-1:0]      periph_src_o,
  output var  logic                           periph_wr_o,
  output var  logic [dma_pkg::DW-1:0]         periph_waddr_o,
  output var  logic [dma_pkg::DW-1:0]         periph_wdata_o,
  output var  logic                           mem_rd_o,
  output var  logic [dma_pkg::DW-1:0]         mem_raddr_o,
  output var  logic                           mem_wr_o,
  output var  logic [dma_pkg::DW-1:0]         mem_waddr_o,
  output var  logic [dma_pkg::DW-1:0]         mem_wdata_o,
  output var  logic [dma_pkg::NCH-1:0]        chan_irq_o
);
  import dma_pkg::*;

  // ****************************************
  // helpers
  // ****************************************
  function automatic logic code_known(input logic [SRC_W-1:0] code);
    logic hit;
    hit = 1'b0;
    for (int i = 0; i < N_CODES; i++) begin
      if (SRC_CODES[i] == code) hit = 1'b1;
    end
    return hit;
  endfunction : code_known

  function automatic logic is_mapped(input logic [DW-1:0] addr);
    logic hit;
    hit = 1'b0;
    for (int i = 0; i < N_MAPPED; i++) begin
      if (PERIPH_MAP[i] == addr) hit = 1'b1;
    end
    return hit;
  endfunction : is_mapped

  function automatic logic [NCH-1:0] below_mask(input logic [CH_W-1:0] idx);
    logic [NCH-1:0] m;
    m = '0;
    for (int i = 0; i < NCH; i++) begin
      if (i < int'(idx)) m[i] = 1'b1;
    end
    return m;
  endfunction : below_mask

  // ****************************************
  // channel state
  // ****************************************
  logic [CON_BITS-1:0] con_reg      [NCH];
  logic [SRC_W-1:0]    req_sel_reg  [NCH];
  logic [DW-1:0]       chan_start_addr_primary   [NCH];
  logic [DW-1:0]       chan_start_addr_secondary [NCH];
  logic [DW-1:0]       chan_periph_addr          [NCH];
  logic [DW-1:0]       chan_transfer_count       [NCH];
  logic [DW-1:0]       done_cnt_reg [NCH];
  logic [NCH-1:0]      ppst_reg;
  logic [NCH-1:0]      pend_reg;
  logic [NCH-1:0]      done_flag_reg;
  logic [3:0]          last_ch_reg;
  xfer_type            s1_reg;
  xfer_type            s1_next;

  logic                wr_chan;
  logic [CH_W-1:0]     wr_ch;
  logic [2:0]          wr_sel;
  logic [NCH-1:0]      req_now;
  logic [NCH-1:0]      force_now;
  logic [NCH-1:0]      cmpl_vec;
  logic [NCH-1:0]      blk_vec;
  logic [NCH-1:0]      elig;
  logic                grant_found;
  logic [CH_W-1:0]     grant_idx;

  assign wr_chan = reg_bus_i.wr && !reg_bus_i.addr[GLOBAL_BIT];
  assign wr_ch   = reg_bus_i.addr[CH_SEL_HI:CH_SEL_LO];
  assign wr_sel  = reg_bus_i.addr[REG_SEL_HI:0];

  // ****************************************
  // request capture and arbitration
  // ****************************************
  always_comb begin
    for (int c = 0; c < NCH; c++) begin
      // every channel watching a line sees it in the same cycle
      req_now[c]   = con_reg[c][CON_EN] && code_known(req_sel_reg[c])
                     && periph_req_i[req_sel_reg[c]];
      force_now[c] = wr_chan && (wr_ch == CH_W'(c)) && (wr_sel == RA_CON)
                     && reg_bus_i.wdata[CON_FORCE] && reg_bus_i.wdata[CON_EN];
      cmpl_vec[c]  = s1_reg.valid && (s1_reg.ch == CH_W'(c));
      blk_vec[c]   = cmpl_vec[c] && s1_reg.last;
    end
  end

  // the channel in flight is not offered again until it completes
  assign elig = pend_reg & ~cmpl_vec;

  always_comb begin
    grant_found = 1'b0;
    grant_idx   = '0;
    for (int c = NCH - 1; c >= 0; c--) begin
      if (elig[c]) begin
        grant_found = 1'b1;
        grant_idx   = CH_W'(c);
      end
    end
  end

  // a new request wins over the completion clear
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      pend_reg <= '0;
    end else begin
      pend_reg <= (pend_reg & ~cmpl_vec) | req_now | force_now;
    end
  end

  // ****************************************
  // read phase, launched the cycle after the grant
  // ****************************************
  always_comb begin
    s1_next          = '0;
    s1_next.valid    = grant_found;
    s1_next.ch       = grant_idx;
    s1_next.dir      = con_reg[grant_idx][CON_DIR];
    s1_next.pind     = con_reg[grant_idx][CON_PIND];
    s1_next.unmapped = !is_mapped(chan_periph_addr[grant_idx]);
    s1_next.last     = done_cnt_reg[grant_idx] == chan_transfer_count[grant_idx];
    s1_next.maddr    = (ppst_reg[grant_idx] ? chan_start_addr_secondary[grant_idx]
                                            : chan_start_addr_primary[grant_idx])
                       + done_cnt_reg[grant_idx];
  end

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      s1_reg         <= '0;
      periph_rd_o    <= 1'b0;
      periph_raddr_o <= '0;
      periph_src_o   <= '0;
      mem_rd_o       <= 1'b0;
      mem_raddr_o    <= '0;
    end else begin
      s1_reg         <= s1_next;
      // no strobe toward an address that nothing answers
      periph_rd_o    <= grant_found && !s1_next.dir && !s1_next.unmapped;
      periph_raddr_o <= chan_periph_addr[grant_idx];
      periph_src_o   <= req_sel_reg[grant_idx];
      mem_rd_o       <= grant_found && s1_next.dir;
      mem_raddr_o    <= s1_next.maddr;
    end
  end

  // ****************************************
  // write phase; read data is taken in the read cycle itself
  // ****************************************
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      mem_wr_o       <= 1'b0;
      mem_waddr_o    <= '0;
      mem_wdata_o    <= '0;
      periph_wr_o    <= 1'b0;
      periph_waddr_o <= '0;
      periph_wdata_o <= '0;
    end else begin
      mem_wr_o       <= s1_reg.valid && !s1_reg.dir;
      mem_waddr_o    <= s1_reg.pind ? periph_ind_addr_i : s1_reg.maddr;
      mem_wdata_o    <= s1_reg.unmapped ? DATA_ZERO : periph_rdata_i;
      periph_wr_o    <= s1_reg.valid && s1_reg.dir && !s1_reg.unmapped;
      periph_waddr_o <= chan_periph_addr[s1_reg.ch];
      periph_wdata_o <= mem_rdata_i;
    end
  end

  // ****************************************
  // channel configuration, counters and ping-pong state
  // ****************************************
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      ppst_reg <= '0;
      for (int c = 0; c < NCH; c++) begin
        con_reg[c]                   <= '0;
        req_sel_reg[c]               <= '0;
        chan_start_addr_primary[c]   <= '0;
        chan_start_addr_secondary[c] <= '0;
        chan_periph_addr[c]          <= '0;
        chan_transfer_count[c]       <= '0;
        done_cnt_reg[c]              <= '0;
      end
    end else begin
      for (int c = 0; c < NCH; c++) begin
        if (blk_vec[c]) begin
          done_cnt_reg[c] <= '0;
          if (con_reg[c][CON_PP]) ppst_reg[c] <= !ppst_reg[c];
          else con_reg[c][CON_EN] <= 1'b0;
        end else if (cmpl_vec[c]) begin
          done_cnt_reg[c] <= done_cnt_reg[c] + 16'h0001;
        end
      end
      // a software write lands after the hardware update of the same cycle
      if (wr_chan) begin
        if (wr_sel == RA_CON) begin
          con_reg[wr_ch] <= reg_bus_i.wdata[CON_BITS-1:0];
          if (reg_bus_i.wdata[CON_EN] && !con_reg[wr_ch][CON_EN]) begin
            done_cnt_reg[wr_ch] <= '0;
            ppst_reg[wr_ch]     <= 1'b0;
          end
        end else if (wr_sel == RA_REQ) begin
          req_sel_reg[wr_ch] <= reg_bus_i.wdata[SRC_W-1:0];
        end else if (wr_sel == RA_STA) begin
          chan_start_addr_primary[wr_ch] <= reg_bus_i.wdata;
        end else if (wr_sel == RA_STB) begin
          chan_start_addr_secondary[wr_ch] <= reg_bus_i.wdata;
        end else if (wr_sel == RA_PAD) begin
          chan_periph_addr[wr_ch] <= reg_bus_i.wdata;
        end else if (wr_sel == RA_CNT) begin
          chan_transfer_count[wr_ch] <= reg_bus_i.wdata;
        end
      end
    end
  end

  // ****************************************
  // block done flags, interrupt pulses, last channel
  // ****************************************
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      done_flag_reg <= '0;
      chan_irq_o    <= '0;
      last_ch_reg   <= LAST_NONE;
    end else begin
      chan_irq_o <= blk_vec;
      if (reg_bus_i.wr && reg_bus_i.addr == GA_STATUS) begin
        done_flag_reg <= (done_flag_reg & ~reg_bus_i.wdata[NCH-1:0]) | blk_vec;
      end else begin
        done_flag_reg <= done_flag_reg | blk_vec;
      end
      if (s1_reg.valid) last_ch_reg <= {1'b0, s1_reg.ch};
    end
  end

  // ****************************************
  // register read port, data one cycle after the strobe
  // ****************************************
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      reg_rdata_o <= '0;
    end else if (!reg_bus_i.rd) begin
      reg_rdata_o <= '0;
    end else if (reg_bus_i.addr == GA_STATUS) begin
      reg_rdata_o <= {4'h0, last_ch_reg, done_flag_reg};
    end else if (reg_bus_i.addr == GA_PEND) begin
      reg_rdata_o <= {ppst_reg, pend_reg};
    end else if (reg_bus_i.addr[GLOBAL_BIT]) begin
      reg_rdata_o <= '0;
    end else if (wr_sel == RA_CON) begin
      reg_rdata_o <= DW'(con_reg[wr_ch]);
    end else if (wr_sel == RA_REQ) begin
      reg_rdata_o <= DW'(req_sel_reg[wr_ch]);
    end else if (wr_sel == RA_STA) begin
      reg_rdata_o <= chan_start_addr_primary[wr_ch];
    end else if (wr_sel == RA_STB) begin
      reg_rdata_o <= chan_start_addr_secondary[wr_ch];
    end else if (wr_sel == RA_PAD) begin
      reg_rdata_o <= chan_periph_addr[wr_ch];
    end else if (wr_sel == RA_CNT) begin
      reg_rdata_o <= chan_transfer_count[wr_ch];
    end else if (wr_sel == RA_STAT) begin
      reg_rdata_o <= done_cnt_reg[wr_ch];
    end else begin
      reg_rdata_o <= '0;
    end
  end

  // ****************************************
  // assertions
  // ****************************************
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (rst_i);

  a_grant_next_cycle: assert property (grant_found |=> s1_reg.valid && s1_reg.ch == $past(grant_idx))
    else $error("granted channel did not transfer next cycle");
  a_fixed_priority: assert property (grant_found |-> (elig & below_mask(grant_idx)) == '0)
    else $error("lower pending channel was passed over");
  a_pend_latched: assert property (
    ##1 ((pend_reg & $past(pend_reg & ~cmpl_vec)) == $past(pend_reg & ~cmpl_vec)))
    else $error("pending request dropped before its transfer");
  a_read_then_write: assert property (s1_reg.valid && !s1_reg.dir |=> mem_wr_o && !periph_wr_o)
    else $error("memory write did not follow the read phase");
  a_unmapped_zero: assert property (s1_reg.valid && !s1_reg.dir && s1_reg.unmapped
    |-> !periph_rd_o ##1 mem_wr_o && mem_wdata_o == DATA_ZERO)
    else $error("unmapped read not returned as zero");
  a_unmapped_drop: assert property (s1_reg.valid && s1_reg.dir && s1_reg.unmapped |=> !periph_wr_o)
    else $error("write to unmapped address was issued");
  a_indirect_addr: assert property (s1_reg.valid && !s1_reg.dir && s1_reg.pind
    |=> mem_waddr_o == $past(periph_ind_addr_i))
    else $error("peripheral supplied address not used");
  a_block_irq: assert property (|blk_vec |=> chan_irq_o == $past(blk_vec)
    ##1 (chan_irq_o & $past(blk_vec, 2)) == '0)
    else $error("block end interrupt wrong");
  a_no_idle_gap: assert property (elig != '0 |=> s1_reg.valid)
    else $error("idle cycle while a request was pending");

  c_back_to_back: cover property (s1_reg.valid ##1 s1_reg.valid && $changed(s1_reg.ch));
  c_block_end:    cover property (|chan_irq_o);
  c_forced:       cover property (|force_now ##[1:4] s1_reg.valid);
  c_shared_src:   cover property ($countones(req_now) > 1);

endmodule : dma_channel_transfer_engine
`default_nettype wire

// ### logic/dma_pkg.sv
// constants, field layout and carrier types for the dma transfer engine
package dma_pkg;

  // ****************************************
  // sizes
  // ****************************************
  localparam int NCH      = 8;
  localparam int CH_W     = 3;
  localparam int DW       = 16;
  localparam int SRC_W    = 7;
  localparam int NSRC     = 128;
  localparam int RA_W     = 8;
  localparam int N_CODES  = 20;
  localparam int N_MAPPED = 20;

  // ****************************************
  // register map: bit 7 set selects the global block,
  // otherwise bits 6:4 pick the channel and bits 2:0 the register
  // ****************************************
  localparam int GLOBAL_BIT = 7;
  localparam int CH_SEL_HI  = 6;
  localparam int CH_SEL_LO  = 4;
  localparam int REG_SEL_HI = 2;
  localparam logic [2:0] RA_CON  = 3'h0;
  localparam logic [2:0] RA_REQ  = 3'h1;
  localparam logic [2:0] RA_STA  = 3'h2;
  localparam logic [2:0] RA_STB  = 3'h3;
  localparam logic [2:0] RA_PAD  = 3'h4;
  localparam logic [2:0] RA_CNT  = 3'h5;
  localparam logic [2:0] RA_STAT = 3'h6;
  localparam logic [RA_W-1:0] GA_STATUS = 8'h80;
  localparam logic [RA_W-1:0] GA_PEND   = 8'h81;

  // control register bits
  localparam int CON_EN    = 0;
  localparam int CON_DIR   = 1;
  localparam int CON_PIND  = 2;
  localparam int CON_PP    = 3;
  localparam int CON_FORCE = 4;
  localparam int CON_BITS  = 4;

  // global status layout: done flags low byte, last channel above
  localparam int LAST_LO = 8;
  localparam logic [3:0] LAST_NONE = 4'hF;
  localparam logic [DW-1:0] DATA_ZERO = 16'h0000;

  // ****************************************
  // request source codes that are wired to a peripheral
  // ****************************************
  localparam logic [N_CODES-1:0][SRC_W-1:0] SRC_CODES = {
    7'h00, 7'h01, 7'h05,          // ext int 0, capture 1, capture 2
    7'h02, 7'h06, 7'h07, 7'h08,   // compare 1, compare 2, timer 2, timer 3
    7'h0A, 7'h21,                 // serial port 1, serial port 2
    7'h0B, 7'h0C, 7'h1E, 7'h1F,   // uart 1 rx/tx, uart 2 rx/tx
    7'h22, 7'h46, 7'h37, 7'h47,   // can 1 rx/tx, can 2 rx/tx
    7'h3C, 7'h0D, 7'h15           // codec done, converter 1, converter 2
  };

  // ****************************************
  // peripheral addresses that answer on the dma bus
  // ****************************************
  localparam logic [N_MAPPED-1:0][DW-1:0] PERIPH_MAP = {
    16'h0140, 16'h0144, 16'h0182, 16'h0180, 16'h0188,
    16'h0186, 16'h0248, 16'h0268, 16'h0226, 16'h0224,
    16'h0236, 16'h0234, 16'h0440, 16'h0442, 16'h0540,
    16'h0542, 16'h0290, 16'h0298, 16'h0300, 16'h0340
  };

  // ****************************************
  // carriers
  // ****************************************
  typedef struct packed {
    logic [RA_W-1:0] addr;
    logic [DW-1:0]   wdata;
    logic            wr;
    logic            rd;
  } reg_req_type;

  typedef struct packed {
    logic            valid;
    logic [CH_W-1:0] ch;
    logic            dir;
    logic            pind;
    logic            unmapped;
    logic            last;
    logic [DW-1:0]   maddr;
  } xfer_type;

endpackage : dma_pkg

// ### verification/dma_channel_transfer_engine_test.sv
// self-checking bench for the dma transfer engine
`timescale 1ns/10ps
`default_nettype none
`define CHK(got, exp) begin check_count++; if ((got) !== (exp)) begin miscompares++; \
  $display("unexpected at %0t: got %h expected %h", $time, got, exp); end end
module dma_channel_transfer_engine_test;
  import dma_pkg::*;
  typedef struct packed {logic pw; logic [15:0] a; logic [15:0] d; logic [31:0] t;} ev_type;
  logic                 core_clk_i = 1'b0;
  logic                 rst_i = 1'b1;
  reg_req_type          reg_bus;
  logic [NSRC-1:0]      req = '0;
  logic [DW-1:0]        reg_rdata, prdata, pia, mrdata, praddr, pwaddr, pwdata, mraddr, mwaddr, mwdata;
  logic [SRC_W-1:0]     src;
  logic                 prd, pwr, mrd, mwr;
  logic [NCH-1:0]       irq;
  logic [31:0]          cyc = 0, last_t, t0;
  int                   miscompares = 0, check_count = 0, irq_cnt[NCH] = '{default: 0};
  ev_type               evq[$];
  logic [SRC_W-1:0]     srcq[$];
  logic [SRC_W-1:0]     codes[18] = '{7'h00, 7'h01, 7'h05, 7'h02, 7'h06, 7'h0A, 7'h21, 7'h0B, 7'h0C,
                                      7'h1E, 7'h1F, 7'h22, 7'h46, 7'h47, 7'h3C, 7'h3C, 7'h0D, 7'h15};
  logic [DW-1:0]        pads[18] = '{16'h0140, 16'h0140, 16'h0144, 16'h0182, 16'h0188, 16'h0248, 16'h0268,
                                     16'h0226, 16'h0224, 16'h0236, 16'h0234, 16'h0440, 16'h0442, 16'h0542,
                                     16'h0290, 16'h0298, 16'h0300, 16'h0340};
  logic                 dirs[18] = '{0, 0, 0, 1, 1, 0, 1, 0, 1, 0, 1, 0, 1, 1, 0, 1, 0, 0};

  always #12.5 core_clk_i = ~core_clk_i;

  dma_channel_transfer_engine u_dma_channel_transfer_engine (
    .core_clk_i(core_clk_i), .rst_i(rst_i), .reg_bus_i(reg_bus), .reg_rdata_o(reg_rdata),
    .periph_req_i(req), .periph_rdata_i(prdata), .periph_ind_addr_i(pia), .mem_rdata_i(mrdata),
    .periph_rd_o(prd), .periph_raddr_o(praddr), .periph_src_o(src), .periph_wr_o(pwr),
    .periph_waddr_o(pwaddr), .periph_wdata_o(pwdata), .mem_rd_o(mrd), .mem_raddr_o(mraddr),
    .mem_wr_o(mwr), .mem_waddr_o(mwaddr), .mem_wdata_o(mwdata), .chan_irq_o(irq));

  dma_far_side_model u_dma_far_side_model (
    .rd_i(prd), .raddr_i(praddr), .src_i(src), .mrd_i(mrd), .mraddr_i(mraddr),
    .rdata_o(prdata), .ind_addr_o(pia), .mem_rdata_o(mrdata));

  // ****************************************
  // monitor: log every write phase with its edge number
  // ****************************************
  always @(posedge core_clk_i) begin
    cyc <= cyc + 1;
    if (mwr) evq.push_back(ev_type'{1'b0, mwaddr, mwdata, cyc});
    if (pwr) evq.push_back(ev_type'{1'b1, pwaddr, pwdata, cyc});
    if (prd | mrd) srcq.push_back(src);
    for (int i = 0; i < NCH; i++) irq_cnt[i] += int'(irq[i]);
  end

  // ****************************************
  // tasks
  // ****************************************
  function automatic logic [7:0] ra(input int c, input logic [2:0] s);
    return {1'b0, c[2:0], 1'b0, s};
  endfunction : ra

  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge core_clk_i);
    reg_bus <= '{a, d, 1'b1, 1'b0};
    @(posedge core_clk_i);
    reg_bus.wr <= 1'b0;
  endtask : wr

  // read data stand one cycle only, so sample mid-cycle
  task automatic rd(input logic [7:0] a, input logic [15:0] exp);
    @(posedge core_clk_i);
    reg_bus <= '{a, 16'h0000, 1'b0, 1'b1};
    @(posedge core_clk_i);
    reg_bus.rd <= 1'b0;
    @(negedge core_clk_i);
    `CHK(reg_rdata, exp)
  endtask : rd

  // control last: channel must be complete before enable
  task automatic setup(input int c, input logic [6:0] code, input logic [15:0] pad, sta, stb, lim, con);
    wr(ra(c, RA_REQ), {9'h000, code});
    wr(ra(c, RA_PAD), pad);
    wr(ra(c, RA_STA), sta);
    wr(ra(c, RA_STB), stb);
    wr(ra(c, RA_CNT), lim);
    wr(ra(c, RA_CON), con);
  endtask : setup

  task automatic go(input logic [6:0] code);
    @(posedge core_clk_i);
    req[code] <= 1'b1;
    @(posedge core_clk_i);
    t0 = cyc;
    req[code] <= 1'b0;
  endtask : go

  task automatic expect_ev(input logic pw, input logic [15:0] a, d);
    ev_type e;
    int     n;
    n = 0;
    while (evq.size() == 0 && n < 20) begin
      @(posedge core_clk_i);
      n++;
    end
    e = (evq.size() > 0) ? evq.pop_front() : ev_type'{1'bx, 16'hXXXX, 16'hXXXX, 32'h0};
    last_t = e.t;
    `CHK({e.pw, e.a, e.d}, {pw, a, d})
  endtask : expect_ev

  task automatic expect_src(input logic [6:0] code);
    logic [6:0] s;
    s = (srcq.size() > 0) ? srcq.pop_front() : 'x;
    `CHK(s, code)
  endtask : expect_src

  task automatic quiet();
    repeat (8) @(posedge core_clk_i);
    `CHK(evq.size(), 0)
  endtask : quiet

  task automatic final_report();
    if (miscompares == 0 && check_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : final_report

  // ****************************************
  // tests
  // ****************************************
  initial begin
    reg_bus = '0;
    repeat (10) @(posedge core_clk_i);
    rst_i <= 1'b0;
    rd(GA_STATUS, {4'h0, LAST_NONE, 8'h00});
    rd(8'h82, 16'h0000);
    setup(0, 7'h0B, 16'h0226, 16'h0100, 16'h0180, 16'h0000, 16'h0001);
    go(7'h0B);
    expect_ev(1'b0, 16'h0100, 16'h0226 ^ 16'h5A5A);
    `CHK(last_t, t0 + 3)
    expect_src(7'h0B);
    `CHK(irq_cnt[0], 1)
    rd(GA_STATUS, 16'h0001);
    wr(GA_STATUS, 16'h0001);
    rd(GA_STATUS, 16'h0000);
    rd(ra(0, RA_CON), 16'h0000);
    // wired codes except 7'h07, 7'h08 and 7'h37, each in its documented direction
    for (int i = 0; i < 18; i++) begin
      setup(0, codes[i], pads[i], 16'h0100 + 16'(i), 16'h0180, 16'h0000, dirs[i] ? 16'h0003 : 16'h0001);
      go(codes[i]);
      if (dirs[i]) expect_ev(1'b1, pads[i], (16'h0100 + 16'(i)) ^ 16'hC3C3);
      else expect_ev(1'b0, 16'h0100 + 16'(i), pads[i] ^ 16'h5A5A);
      expect_src(codes[i]);
    end
    setup(0, 7'h03, 16'h0140, 16'h0100, 16'h0180, 16'h0000, 16'h0001);
    go(7'h03);
    quiet();
    // one source, two channels: lower number first, next one without a gap
    setup(1, 7'h0A, 16'h0248, 16'h0200, 16'h0280, 16'h0000, 16'h0003);
    setup(2, 7'h0A, 16'h0248, 16'h0300, 16'h0380, 16'h0000, 16'h0001);
    go(7'h0A);
    expect_ev(1'b1, 16'h0248, 16'h0200 ^ 16'hC3C3);
    `CHK(last_t, t0 + 3)
    expect_ev(1'b0, 16'h0300, 16'h0248 ^ 16'h5A5A);
    `CHK(last_t, t0 + 4)
    void'(srcq.size());
    srcq.delete();
    setup(3, 7'h0D, 16'h0444, 16'h0400, 16'h0480, 16'h0000, 16'h0001);
    go(7'h0D);
    expect_ev(1'b0, 16'h0400, 16'h0000);
    `CHK(srcq.size(), 0)
    setup(3, 7'h0D, 16'h0444, 16'h0400, 16'h0480, 16'h0000, 16'h0003);
    go(7'h0D);
    quiet();
    setup(4, 7'h7F, 16'h0300, 16'h0500, 16'h0580, 16'h0000, 16'h0000);
    wr(ra(4, RA_CON), 16'h0011);
    expect_ev(1'b0, 16'h0500, 16'h0300 ^ 16'h5A5A);
    rd(ra(4, RA_REQ), 16'h007F);
    rd(ra(4, RA_PAD), 16'h0300);
    setup(5, 7'h0D, 16'h0300, 16'h0600, 16'h0680, 16'h0000, 16'h0005);
    go(7'h0D);
    expect_ev(1'b0, 16'h040D, 16'h0300 ^ 16'h5A5A);
    // limit 2 means three words, interrupt only on the last
    setup(6, 7'h15, 16'h0340, 16'h0700, 16'h0780, 16'h0002, 16'h0001);
    for (int k = 0; k < 3; k++) begin
      go(7'h15);
      expect_ev(1'b0, 16'h0700 + 16'(k), 16'h0340 ^ 16'h5A5A);
      repeat (2) @(posedge core_clk_i);
      `CHK(irq_cnt[6], (k == 2) ? 1 : 0)
      rd(ra(6, RA_STAT), (k == 2) ? 16'h0000 : 16'(k + 1));
    end
    setup(7, 7'h1E, 16'h0236, 16'h0780, 16'h07C0, 16'h0000, 16'h0009);
    go(7'h1E);
    expect_ev(1'b0, 16'h0780, 16'h0236 ^ 16'h5A5A);
    rd(GA_PEND, 16'h8000);
    rd(ra(6, RA_CNT), 16'h0002);
    rd(ra(7, RA_STB), 16'h07C0);
    go(7'h1E);
    expect_ev(1'b0, 16'h07C0, 16'h0236 ^ 16'h5A5A);
    final_report();
  end

  // whole run is a few hundred cycles
  initial begin
    repeat (20000) @(posedge core_clk_i);
    miscompares++;
    final_report();
  end
endmodule : dma_channel_transfer_engine_test
`default_nettype wire

// ### verification/dma_far_side_model.sv
// peripheral and dual port memory stand-in for the dma engine bench
`timescale 1ns/10ps
`default_nettype none
module dma_far_side_model
  import dma_pkg::*;
(
  input  wire logic                      rd_i,
  input  wire logic [dma_pkg::DW-1:0]    raddr_i,
  input  wire logic [dma_pkg::SRC_W-1:0] src_i,
  input  wire logic                      mrd_i,
  input  wire logic [dma_pkg::DW-1:0]    mraddr_i,
  output var  logic [dma_pkg::DW-1:0]    rdata_o,
  output var  logic [dma_pkg::DW-1:0]    ind_addr_o,
  output var  logic [dma_pkg::DW-1:0]    mem_rdata_o
);
  // ****************************************
  // answers
  // ****************************************
  // values hold only beside the strobe; inverted otherwise so a late sample never matches
  always_comb begin
    rdata_o     = rd_i ? (raddr_i ^ 16'h5A5A) : ~(raddr_i ^ 16'h5A5A);
    ind_addr_o  = (rd_i | mrd_i) ? (16'h0400 + {9'h000, src_i}) : ~(16'h0400 + {9'h000, src_i});
    mem_rdata_o = mrd_i ? (mraddr_i ^ 16'hC3C3) : ~(mraddr_i ^ 16'hC3C3);
  end
endmodule : dma_far_side_model
`default_nettype wire
